// ---- rtl/repeater_phy_port.v ----
`timescale 1ns/1ps
`include "phy_port_defs.vh"
// Contract
// - Receive enable polarity follows strap level
// - Error line high makes nibble error type
// - Errors forwarded only to inter-repeater side
// - Codes 3h and 4h never seen
// - Receive enable only while carrier present, except all ports enabled just after reset with a pulled-down strap
// - Receive lines sampled on clock fall
// - Carrier inputs synchronised before use
// - Transmit enables active high per port
// - Transmit busy is OR of enables
// - Transmit error high for violation nibbles while a port is selected
// - Shared transmit nibble drives all PHYs
// - Error sent active low to inter-repeater
module repeater_phy_port (
	input  wire       clk,
	input  wire       reset_n,
	input  wire       receive_enable_polarity_strap,
	input  wire [7:0] carrier_sense,
	input  wire       rx_clk,
	input  wire [3:0] rx_data,
	input  wire       rx_valid,
	input  wire       rx_error,
	input  wire [7:0] tx_port_select,
	input  wire [3:0] tx_data_in,
	input  wire       tx_violation,
	output reg  [7:0] port_receive_enable,
	output reg  [3:0] rx_nibble_out,
	output reg        rx_valid_out,
	output reg        rx_nibble_strobe,
	output reg  [2:0] rx_active_port,
	output reg        inter_repeater_error_n,
	output reg  [3:0] ir_error_type,
	output reg  [3:0] local_rx_nibble,
	output reg  [7:0] port_transmit_enable,
	output reg        tx_busy,
	output reg        tx_error,
	output reg  [3:0] tx_data
);
	// Synchronised carriers, strap, receive clock and receive lines
	wire [7:0] crs_sync;
	reg        strap_meta_reg;
	reg        strap_sync_reg;
	wire       rxc_sync;
	wire [3:0] rxd_sync;
	wire       rxdv_sync;
	wire       rxer_sync;

	reg        arb_state_reg;
	reg        arb_state_next;
	reg  [2:0] grant_reg;
	reg  [2:0] grant_next;
	reg        pol_high_reg;
	reg        rxc_prev_reg;
	reg  [7:0] onehot;
	reg        found;
	integer    i;

	// Carrier inputs are asynchronous
	genvar g;
	generate
		for (g = 0; g < `NUM_PORTS; g = g + 1) begin : g_crs
			sync2 u_crs (
				.clk     (clk),
				.reset_n (reset_n),
				.d       (carrier_sense[g]),
				.q       (crs_sync[g])
			);
		end
		for (g = 0; g < `NIBBLE_W; g = g + 1) begin : g_rxd
			sync2 u_rxd (
				.clk     (clk),
				.reset_n (reset_n),
				.d       (rx_data[g]),
				.q       (rxd_sync[g])
			);
		end
	endgenerate

	// Strap synchroniser resets to the open-strap level, so with an open strap
	// enables stay inactive while the strap is still being sampled
	// Limitation: a pulled-down strap reads as active high for the
	// first few cycles after reset, with all enables at 00
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			strap_meta_reg <= 1'b1;
			strap_sync_reg <= 1'b1;
		end else begin
			strap_meta_reg <= receive_enable_polarity_strap;
			strap_sync_reg <= strap_meta_reg;
		end
	end

	// Receive clock and lines share one latency, so the nibble seen
	// at a detected fall is the one that stood across that fall
	sync2 u_rxc (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (rx_clk),
		.q       (rxc_sync)
	);
	sync2 u_rxdv (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (rx_valid),
		.q       (rxdv_sync)
	);
	sync2 u_rxer (
		.clk     (clk),
		.reset_n (reset_n),
		.d       (rx_error),
		.q       (rxer_sync)
	);

	// Falling edge of the synchronised receive clock
	wire rxc_fall = rxc_prev_reg & ~rxc_sync;

	// Lowest carrying port wins the shared receive bus
	always @* begin
		found = 1'b0;
		grant_next = grant_reg;
		arb_state_next = arb_state_reg;
		for (i = `NUM_PORTS - 1; i >= 0; i = i - 1) begin
			if (crs_sync[i]) begin
				found = 1'b1;
				grant_next = i[2:0];
			end
		end
		case (arb_state_reg)
			`ARB_IDLE: begin
				if (found)
					arb_state_next = `ARB_GRANT;
			end
			`ARB_GRANT: begin
				// Hold the grant until its carrier drops
				if (crs_sync[grant_reg])
					grant_next = grant_reg;
				else
					arb_state_next = `ARB_IDLE;
			end
			default: arb_state_next = `ARB_IDLE;
		endcase
	end

	// One-hot enable of the granted port only
	// Gating on live carrier keeps codes 3h and 4h off the bus,
	// since a PHY only shows them with its carrier low
	always @* begin
		onehot = 8'h00;
		if (arb_state_reg == `ARB_GRANT && crs_sync[grant_reg])
			onehot[grant_reg] = 1'b1;
	end

	// Strap caught after release; arbiter registers
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			arb_state_reg <= `ARB_IDLE;
			grant_reg     <= 3'h0;
			pol_high_reg  <= 1'b1;
			rxc_prev_reg  <= 1'b0;
			port_receive_enable <= 8'h00;
		end else begin
			arb_state_reg <= arb_state_next;
			grant_reg     <= grant_next;
			pol_high_reg  <= strap_sync_reg;
			rxc_prev_reg  <= rxc_sync;
			// Inactive level is the opposite of the strap polarity
			port_receive_enable <= pol_high_reg ? onehot : ~onehot;
		end
	end

	// Receive data path, sampled at receive clock fall
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rx_nibble_out          <= 4'h0;
			rx_valid_out           <= 1'b0;
			rx_nibble_strobe       <= 1'b0;
			rx_active_port         <= 3'h0;
			inter_repeater_error_n <= 1'b1;
			ir_error_type          <= 4'h0;
			local_rx_nibble        <= 4'h0;
		end else begin
			rx_nibble_strobe <= rxc_fall & (arb_state_reg == `ARB_GRANT);
			if (rxc_fall) begin
				rx_nibble_out  <= rxd_sync;
				rx_valid_out   <= rxdv_sync;
				rx_active_port <= grant_reg;
				// Error sampled at receive clock fall and held, active low
				inter_repeater_error_n <= ~rxer_sync;
				// Error type goes to inter-repeater side only
				ir_error_type <= rxer_sync ? rxd_sync : 4'h0;
				// Local ports never see error nibbles
				if (!rxer_sync)
					local_rx_nibble <= rxd_sync;
			end
		end
	end

	// Transmit side; violation forces a fixed nibble with error high
	// Requests come from the same clock, so no synchroniser here;
	// the error line stays low when no port is selected
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			port_transmit_enable <= 8'h00;
			tx_busy              <= 1'b0;
			tx_error             <= 1'b0;
			tx_data              <= 4'h0;
		end else begin
			port_transmit_enable <= tx_port_select;
			tx_busy  <= |tx_port_select;
			tx_error <= tx_violation & (|tx_port_select);
			tx_data  <= tx_violation ? `TX_IDLE_NIBBLE : tx_data_in;
		end
	end
endmodule // repeater_phy_port

// ---- pkg/phy_port_defs.vh ----
`ifndef PHY_PORT_DEFS_VH
`define PHY_PORT_DEFS_VH

// Port count and nibble width
`define NUM_PORTS        8
`define NIBBLE_W         4

// Error type codes carried on the receive nibble while the error line is high
`define ERR_CODE_VIOL    4'h0
`define ERR_CODE_EBUF    4'h1
`define ERR_CODE_TERM    4'h2
`define ERR_CODE_RSVD    4'h3
`define ERR_CODE_10MB    4'h4

// Transmit nibble sent while a code violation is forced
`define TX_IDLE_NIBBLE   4'h0

// Arbiter states
`define ARB_IDLE         1'b0
`define ARB_GRANT        1'b1

`endif

// ---- rtl/sync2.v ----
`timescale 1ns/1ps
// Two-flop synchroniser for one asynchronous level
module sync2 (
	input  wire clk,
	input  wire reset_n,
	input  wire d,
	output reg  q
);
	reg meta_reg;

	// First stage is read by the second stage only
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_reg <= 1'b0;
			q        <= 1'b0;
		end else begin
			meta_reg <= d;
			q        <= meta_reg;
		end
	end
endmodule // sync2

// ---- tb/phy_model.sv ----
`timescale 1ns/1ps
// Far-side PHY group; a released bus drops low or shows inverted data
module phy_model (
	output logic [7:0] carrier_sense,
	output logic       rx_clk,
	output logic [3:0] rx_data,
	output logic       rx_valid,
	output logic       rx_error
);
	initial {carrier_sense, rx_clk, rx_data, rx_valid, rx_error} = 15'h0;
	// Launch at the rise so the nibble is steady over the fall
	// Carrier changes land after the edge, never racing the sampler
	task crs(logic [7:0] v);
		carrier_sense <= v;
	endtask
	task send(logic [3:0] d, logic e);
		{rx_clk, rx_data, rx_valid, rx_error} <= {1'b1, d, 1'b1, e};
		#62.5 rx_clk = 0;
		#62.5 {rx_data, rx_valid, rx_error} = {~d, 2'b00};
	endtask
endmodule // phy_model

// ---- tb/repeater_phy_port_monitor.sv ----
`timescale 1ns/1ps
// Checks beside the PHY-side ports
module repeater_phy_port_monitor (
	input wire       clk, reset_n, receive_enable_polarity_strap, rx_error,
	input wire       tx_violation, rx_nibble_strobe, inter_repeater_error_n,
	input wire       tx_busy, tx_error,
	input wire [7:0] carrier_sense, tx_port_select, port_receive_enable,
	input wire [7:0] port_transmit_enable
);
	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);
	// Grant: one owner, carrier allowed its sync delay
	AST_ONE: assert property ($onehot0(port_receive_enable) ||
		$onehot0(~port_receive_enable)) else $error("enables");
	AST_CRS: assert property (receive_enable_polarity_strap |->
		!(port_receive_enable & ~$past(carrier_sense, 4))) else $error("crs");
	AST_STB: assert property (rx_nibble_strobe |=> !rx_nibble_strobe)
		else $error("strobe");
	AST_IRE: assert property ($rose(rx_nibble_strobe) |->
		inter_repeater_error_n != rx_error) else $error("ir error");
	// Transmit outputs one cycle after the request
	AST_BSY: assert property (tx_busy == |port_transmit_enable)
		else $error("busy");
	AST_TXE: assert property (
		port_transmit_enable == $past(tx_port_select)) else $error("txe");
	AST_TXR: assert property ($past(tx_violation) |->
		tx_error == |port_transmit_enable) else $error("txer");
	AST_IDL: assert property (!$past(tx_violation) |-> !tx_error)
		else $error("idle");
endmodule // repeater_phy_port_monitor

bind repeater_phy_port repeater_phy_port_monitor u_mon (.*);

// ---- tb/repeater_phy_port_tb.sv ----
`timescale 1ns/1ps
module repeater_phy_port_tb;
	logic       clk = 0, reset_n = 0, receive_enable_polarity_strap = 1;
	logic       tx_violation = 0;
	logic [7:0] tx_port_select = 8'h00;
	logic [3:0] tx_data_in = 4'h9;
	wire  [7:0] carrier_sense, port_receive_enable, port_transmit_enable;
	wire  [3:0] rx_data, rx_nibble_out, ir_error_type, local_rx_nibble, tx_data;
	wire        rx_clk, rx_valid, rx_error, inter_repeater_error_n;
	wire        tx_busy, tx_error, rx_valid_out;
	wire  [2:0] rx_active_port;
	int         errors = 0, n_tests = 0, cycles = 0;
	always #2 clk = ~clk;
	repeater_phy_port u_dut (.*, .rx_nibble_strobe());
	phy_model u_phy (.*);
	// Hang guard, well past the expected run
	always @(posedge clk) if (++cycles > 9999) begin
		errors++;
		wrap_up();
	end
	task check(string n, logic [7:0] s, e);
		n_tests++;
		if (s !== e) $display("wrong value %s exp %h seen %h", n, e, s);
		errors += (s !== e);
	endtask
	task wrap_up;
		$display("%0d checks, %0d errors", n_tests, errors);
		if (errors == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task rst(logic s);
		reset_n <= 0;
		tx_port_select <= 8'h00;
		tx_violation <= 0;
		receive_enable_polarity_strap <= s;
		repeat (2) @(posedge clk);
		reset_n <= 1;
	endtask
	// Bounded wait, since grant goes through synchronisers
	task rxen(logic [7:0] e);
		for (int i = 0; i < 16 && port_receive_enable !== e; i++) @(posedge clk);
		check("rxen", port_receive_enable, e);
	endtask
	task t_tx(logic [7:0] s, logic v);
		tx_port_select <= s;
		tx_violation <= v;
		repeat (2) @(posedge clk);
		check("txen", port_transmit_enable, s);
		check("busy", tx_busy, |s);
		check("txer", tx_error, v && s);
		check("txd", tx_data, v ? 4'h0 : 4'h9);
		$display("tx case done");
	endtask
	// Lowest carrier wins; errors stay off the local path
	task t_rx;
		u_phy.crs(8'h24);
		rxen(8'h04);
		u_phy.send(4'ha, 0);
		check("rxd", rx_nibble_out, 4'ha);
		check("dv", rx_valid_out, 1);
		check("port", rx_active_port, 2);
		@(posedge clk);
		u_phy.send(4'h2, 1);
		check("type", ir_error_type, 4'h2);
		check("ire", inter_repeater_error_n, 0);
		check("local", local_rx_nibble, 4'ha);
		u_phy.crs(8'h20);
		rxen(8'h20);
		$display("rx test done");
	endtask
	task t_pol;
		u_phy.crs(8'h00);
		rst(0);
		rxen(8'hff);
		u_phy.crs(8'h08);
		rxen(8'hf7);
		$display("polarity test done");
	endtask
	initial begin
		rst(1);
		t_tx(8'ha5, 0);
		t_tx(8'h80, 1);
		t_tx(8'h00, 1);
		t_rx;
		t_pol;
		wrap_up();
	end
endmodule // repeater_phy_port_tb
